/* design/sar_pkg.sv */
// shared constants and types of the serial converter link
package sar_pkg;
    localparam int RES_W          = 8;
    localparam int SYS_CLK_NS     = 40;
    localparam int SAMPLE_EDGE    = 4;
    localparam int LAST_EDGE      = 8;
    localparam int HOLD_CYC       = 4;
    localparam int CONV_CYC       = 32;
    localparam int STEP_CYC       = CONV_CYC / RES_W;
    localparam int CONV_MAX_US    = 17;
    localparam int CONV_MAX_CYC   = CONV_MAX_US * 1000 / SYS_CLK_NS;
    localparam int REPEAT_FAST_US = 22;
    localparam int REPEAT_SLOW_US = 25;
    localparam int REPEAT_CYC     = REPEAT_FAST_US * 1000 / SYS_CLK_NS;
    localparam int SCLK_PERIOD_NS = 320;
    localparam int SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * SYS_CLK_NS);
    localparam int SETUP_CYC      = 8;
    localparam int GAP_CYC        = HOLD_CYC + CONV_CYC + 4;
    localparam int FIFO_DEPTH     = 32;
    localparam int FIFO_W         = RES_W;
    localparam logic [RES_W-1:0] RESULT_RST = 8'h00;

    typedef enum logic [1:0] {
        SAR_IDLE = 2'b00,
        SAR_HOLD = 2'b01,
        SAR_CONV = 2'b10
    } sar_phase_e;

    typedef enum logic [2:0] {
        SAR_H_IDLE  = 3'b000,
        SAR_H_SETUP = 3'b001,
        SAR_H_HIGH  = 3'b010,
        SAR_H_LOW   = 3'b011,
        SAR_H_GAP   = 3'b100
    } sar_host_e;
endpackage

/* design/sar_link_if.sv */
// three-wire link between controller and converter
`timescale 1ns/1ps
`default_nettype none
interface sar_link_if;
    logic sel_n;
    logic sclk;
    logic dout;
    logic dout_oe;
    logic dout_bus;

    // a released line shows the inverse of the last bit, so a read that
    // ignores the enable cannot pass by luck
    assign dout_bus = dout_oe ? dout : ~dout;

    modport dev (
        input  sel_n,
        input  sclk,
        output dout,
        output dout_oe
    );

    modport host (
        output sel_n,
        output sclk,
        input  dout_bus,
        input  dout_oe
    );
endinterface
`default_nettype wire

/* design/sar_fifo.sv */
// shift-style result fifo, head entry is a flop
`timescale 1ns/1ps
`default_nettype none
module sar_fifo #(
    parameter int WIDTH = sar_pkg::FIFO_W,
    parameter int DEPTH = sar_pkg::FIFO_DEPTH
) (
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          not_empty;
        logic          not_full;
    } sar_fifo_s;

    sar_fifo_s        r;
    sar_fifo_s        next_r;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;
    logic [CW-1:0]    wr_idx;

    assign push   = in_valid_i && r.not_full;
    assign pop    = r.not_empty && out_ready_i;
    assign wr_idx = pop ? r.cnt - CW'(1) : r.cnt;

    always_comb begin
        next_r = r;
        next_r.cnt = r.cnt + CW'(push) - CW'(pop);
        next_r.not_empty = next_r.cnt != '0;
        next_r.not_full  = next_r.cnt != CW'(DEPTH);
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // data entries carry no reset; validity lives in the count
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge clk_i) begin
            if (push && wr_idx == CW'(i)) begin
                mem[i] <= in_data_i;
            end else if (pop) begin
                if (i < DEPTH - 1) begin
                    mem[i] <= mem[(i + 1) % DEPTH];
                end
            end
        end
    end

    assign in_ready_o  = r.not_full;
    assign out_valid_o = r.not_empty;
    assign out_data_o  = mem[0];
endmodule // sar_fifo
`default_nettype wire

/* design/sar_host_end.sv */
// controller end: makes select and shift clock, reads results
`timescale 1ns/1ps
`default_nettype none
module sar_host_end (
    input  wire logic                     clk_i,
    input  wire logic                     reset_i,
    sar_link_if.host                      link,
    input  wire logic                     run_i,
    output logic      [sar_pkg::RES_W-1:0] rd_data_o,
    output logic                          rd_valid_o,
    input  wire logic                     rd_ready_i,
    output logic                          busy_o
);
    typedef struct packed {
        sar_pkg::sar_host_e        state;
        logic [5:0]                tmr;
        logic [3:0]                nbit;
        logic [sar_pkg::RES_W-1:0] shreg;
        logic                      sel_n;
        logic                      sclk;
        logic                      din_m;
        logic                      din_s;
        logic                      push;
        logic                      busy;
    } sar_host_s;

    sar_host_s r;
    sar_host_s next_r;
    logic      fifo_ready;

    always_comb begin
        next_r = r;
        next_r.din_m = link.dout_bus;
        next_r.din_s = r.din_m;
        next_r.push  = 1'b0;
        next_r.tmr   = r.tmr + 6'd1;
        case (r.state)
            sar_pkg::SAR_H_IDLE: begin
                next_r.sel_n = 1'b1;
                next_r.sclk  = 1'b0;
                next_r.busy  = 1'b0;
                // a free slot is held back for this frame's byte
                if (run_i && fifo_ready) begin
                    next_r.state = sar_pkg::SAR_H_SETUP;
                    next_r.sel_n = 1'b0;
                    next_r.busy  = 1'b1;
                    next_r.tmr   = '0;
                    next_r.nbit  = '0;
                end
            end
            sar_pkg::SAR_H_SETUP: begin
                if (r.tmr == 6'(sar_pkg::SETUP_CYC - 1)) begin
                    next_r.state = sar_pkg::SAR_H_HIGH;
                    next_r.sclk  = 1'b1;
                    next_r.tmr   = '0;
                end
            end
            sar_pkg::SAR_H_HIGH: begin
                if (r.tmr == 6'(sar_pkg::SCLK_HALF_CYC - 1)) begin
                    // bit stable since last fall; capture before next fall
                    next_r.shreg = {r.shreg[sar_pkg::RES_W-2:0], r.din_s};
                    next_r.sclk  = 1'b0;
                    next_r.nbit  = r.nbit + 4'd1;
                    next_r.tmr   = '0;
                    next_r.state = sar_pkg::SAR_H_LOW;
                    // eighth fall is placed at the capture instant
                    if (r.nbit == 4'(sar_pkg::LAST_EDGE - 1)) begin
                        next_r.state = sar_pkg::SAR_H_GAP;
                        next_r.push  = 1'b1;
                    end
                end
            end
            sar_pkg::SAR_H_LOW: begin
                if (r.tmr == 6'(sar_pkg::SCLK_HALF_CYC - 1)) begin
                    next_r.state = sar_pkg::SAR_H_HIGH;
                    next_r.sclk  = 1'b1;
                    next_r.tmr   = '0;
                end
            end
            sar_pkg::SAR_H_GAP: begin
                // select rises a cycle after the last fall: moving both
                // pins at once would hide that fall behind the deselect
                if (r.tmr == 6'd0) begin
                    next_r.sel_n = 1'b1;
                end
                // select stays high until hold and conversion are over
                if (r.tmr == 6'(sar_pkg::GAP_CYC - 1)) begin
                    next_r.state = sar_pkg::SAR_H_IDLE;
                end
            end
            default: begin
                next_r.state = sar_pkg::SAR_H_IDLE;
                next_r.sel_n = 1'b1;
                next_r.sclk  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            r <= '{state: sar_pkg::SAR_H_IDLE, sel_n: 1'b1, default: '0};
        end else begin
            r <= next_r;
        end
    end

    sar_fifo #(
        .WIDTH (sar_pkg::FIFO_W),
        .DEPTH (sar_pkg::FIFO_DEPTH)
    ) u_sar_fifo (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .in_valid_i  (r.push),
        .in_ready_o  (fifo_ready),
        .in_data_i   (r.shreg),
        .out_valid_o (rd_valid_o),
        .out_ready_i (rd_ready_i),
        .out_data_o  (rd_data_o)
    );

    // sclk edges come from the divider only, so no glitches
    assign link.sel_n = r.sel_n;
    assign link.sclk  = r.sclk;
    assign busy_o     = r.busy;
endmodule // sar_host_end
`default_nettype wire

/* design/sar_dev_end.sv */
// converter end: serial readout, sample, hold and conversion
//
// Summary of operation
// - select high: output floats, shift clock ignored
// - falls one to four shift bits two-five
// - sampling begins after the fourth fall
// - falls five to seven shift bits six-eight
// - eighth fall: hold for four system cycles
// - then convert over 32 cycles, 36 total
// - controller waits 36 cycles after eighth edge
// - select may stay low; clock glitch-free
// - raised select stays high until conversion ends
// - select falling mid-conversion resets and aborts
// - full new sequence aborts, restarts, gives old result
// - sampling continues until the eighth fall
// - eighth fall placed at capture instant
// - system clock independent of shift clock
// - conversion within 17 us, repeat within 22/25
// - result kept in register for next readout
// - sampling window at most four shift cycles
`timescale 1ns/1ps
`default_nettype none
module sar_dev_end (
    input  wire logic                      clk_i,
    input  wire logic                      reset_i,
    sar_link_if.dev                        link,
    input  wire logic [sar_pkg::RES_W-1:0] ain_i,
    output logic                           sampling_o,
    output logic                           holding_o,
    output logic                           busy_o,
    output logic                           done_o,
    output logic      [sar_pkg::RES_W-1:0] result_o
);
    typedef struct packed {
        logic                      sel_m;
        logic                      sel_s;
        logic                      sel_q;
        logic                      clk_m;
        logic                      clk_s;
        logic                      clk_q;
        logic [sar_pkg::RES_W-1:0] ain_m;
        logic [sar_pkg::RES_W-1:0] ain_s;
        sar_pkg::sar_phase_e       phase;
        logic [5:0]                tcnt;
        logic [2:0]                sbit;
        logic [3:0]                nbit;
        logic [sar_pkg::RES_W-1:0] shreg;
        logic [sar_pkg::RES_W-1:0] held;
        logic [sar_pkg::RES_W-1:0] approx;
        logic [sar_pkg::RES_W-1:0] result;
        logic                      dout;
        logic                      dout_oe;
        logic                      sampling;
        logic                      done;
        logic                      holding;
        logic                      busy;
    } sar_dev_s;

    sar_dev_s                  r;
    sar_dev_s                  next_r;
    logic                      sel_fall;
    logic                      sclk_fall;
    logic [sar_pkg::RES_W-1:0] trial;

    // pins and analog stand-in are foreign to clk_i, two flops each
    assign sel_fall  = r.sel_q && !r.sel_s;
    assign sclk_fall = r.clk_q && !r.clk_s && !r.sel_s;
    assign trial     = r.approx | (sar_pkg::RES_W'(1) << r.sbit);

    always_comb begin
        next_r = r;
        next_r.sel_m = link.sel_n;
        next_r.sel_s = r.sel_m;
        next_r.sel_q = r.sel_s;
        next_r.clk_m = link.sclk;
        next_r.clk_s = r.clk_m;
        next_r.clk_q = r.clk_s;
        next_r.ain_m = ain_i;
        next_r.ain_s = r.ain_m;
        next_r.done  = 1'b0;

        // conversion timing runs on clk_i alone, never on sclk
        case (r.phase)
            sar_pkg::SAR_HOLD: begin
                next_r.tcnt = r.tcnt + 6'd1;
                if (r.tcnt == 6'(sar_pkg::HOLD_CYC - 1)) begin
                    next_r.phase  = sar_pkg::SAR_CONV;
                    next_r.tcnt   = '0;
                    next_r.sbit   = 3'(sar_pkg::RES_W - 1);
                    next_r.approx = '0;
                end
            end
            sar_pkg::SAR_CONV: begin
                next_r.tcnt = r.tcnt + 6'd1;
                // one trial bit per step, MSB first
                if (r.tcnt[1:0] == 2'(sar_pkg::STEP_CYC - 1)) begin
                    if (trial <= r.held) begin
                        next_r.approx = trial;
                    end
                    next_r.sbit = r.sbit - 3'd1;
                end
                if (r.tcnt == 6'(sar_pkg::CONV_CYC - 1)) begin
                    next_r.phase  = sar_pkg::SAR_IDLE;
                    next_r.result = (trial <= r.held) ? trial : r.approx;
                    next_r.done   = 1'b1;
                    // nothing shifted yet: show the fresh result at once
                    if (!r.sel_s && r.nbit == 4'd0) begin
                        next_r.shreg = next_r.result;
                        next_r.dout  = next_r.result[sar_pkg::RES_W-1];
                    end
                end
            end
            default: begin
                next_r.phase = sar_pkg::SAR_IDLE;
                next_r.tcnt  = '0;
            end
        endcase

        if (r.sel_s) begin
            // deselected: float and forget any partial transfer
            next_r.dout_oe  = 1'b0;
            next_r.nbit     = '0;
            next_r.sampling = 1'b0;
        end else if (sel_fall) begin
            // a fresh select acts as the reset of the sequence
            next_r.phase    = sar_pkg::SAR_IDLE;
            next_r.tcnt     = '0;
            next_r.done     = 1'b0;
            next_r.nbit     = '0;
            next_r.sampling = 1'b0;
            next_r.shreg    = r.result;
            next_r.dout     = r.result[sar_pkg::RES_W-1];
            next_r.dout_oe  = 1'b1;
        end else if (sclk_fall) begin
            next_r.nbit  = r.nbit + 4'd1;
            next_r.shreg = {r.shreg[sar_pkg::RES_W-2:0], 1'b0};
            next_r.dout  = r.shreg[sar_pkg::RES_W-2];
            if (r.nbit == 4'(sar_pkg::SAMPLE_EDGE - 1)) begin
                next_r.sampling = 1'b1;
            end
            if (r.nbit == 4'(sar_pkg::LAST_EDGE - 1)) begin
                // track ends exactly four shift cycles after it began
                next_r.sampling = 1'b0;
                next_r.held     = r.ain_s;
                // restart even if a conversion is still running
                next_r.phase    = sar_pkg::SAR_HOLD;
                next_r.tcnt     = '0;
                next_r.done     = 1'b0;
                next_r.nbit     = '0;
                // aborted work never reaches the result register
                next_r.shreg    = r.result;
                next_r.dout     = r.result[sar_pkg::RES_W-1];
            end
        end

        // flopped phase decode, so the status outputs come from flops
        next_r.holding = next_r.phase == sar_pkg::SAR_HOLD;
        next_r.busy    = next_r.phase != sar_pkg::SAR_IDLE;
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            r <= '{
                sel_m:  1'b1,
                sel_s:  1'b1,
                sel_q:  1'b1,
                phase:  sar_pkg::SAR_IDLE,
                result: sar_pkg::RESULT_RST,
                shreg:  sar_pkg::RESULT_RST,
                default: '0
            };
        end else begin
            r <= next_r;
        end
    end

    assign link.dout    = r.dout;
    assign link.dout_oe = r.dout_oe;
    assign sampling_o   = r.sampling;
    assign holding_o    = r.holding;
    assign busy_o       = r.busy;
    assign done_o       = r.done;
    assign result_o     = r.result;
endmodule // sar_dev_end
`default_nettype wire

/* verification/sar_link_properties.sv */
// assertions on the three-wire link and the converter timing outputs
`timescale 1ns/1ps
`default_nettype none
module sar_link_properties (
    input  wire logic                      clk_i,
    input  wire logic                      reset_i,
    input  wire logic                      sel_n,
    input  wire logic                      sclk,
    input  wire logic                      dout,
    input  wire logic                      dout_oe,
    input  wire logic                      sampling_o,
    input  wire logic                      holding_o,
    input  wire logic                      busy_o,
    input  wire logic                      done_o,
    input  wire logic [sar_pkg::RES_W-1:0] result_o
);
    localparam int CONV_MAX = sar_pkg::CONV_MAX_CYC;
    logic       sclk_q;
    logic       framed;
    logic [3:0] fall_cnt;
    logic [5:0] busy_cnt;
    logic [5:0] high_cnt;
    logic       fall;
    logic       eighth;

    assign fall   = sclk_q & ~sclk;
    assign eighth = fall && (fall_cnt == 4'h7);

    // fall count restarts whenever select is high and no fall is seen, high count whenever it is low, busy count whenever busy is low
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sclk_q   <= 1'b0;
            framed   <= 1'b0;
            fall_cnt <= 4'h0;
            busy_cnt <= 6'h00;
            high_cnt <= 6'h00;
        end else begin
            sclk_q   <= sclk;
            framed   <= framed | eighth;
            fall_cnt <= fall ? fall_cnt + 4'h1 : (sel_n ? 4'h0 : fall_cnt);
            busy_cnt <= busy_o ? busy_cnt + 6'h01 : 6'h00;
            high_cnt <= !sel_n ? 6'h00
                      : (high_cnt == 6'h3f ? high_cnt : high_cnt + 6'h01);
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    a_float_deselected: assert property (sel_n [*4] |-> !dout_oe)
        else $error("output driven while deselected");
    a_msb_on_select: assert property ($fell(sel_n) |-> ##3
        (dout_oe && dout == result_o[sar_pkg::RES_W-1]))
        else $error("first bit not presented after select");
    a_sample_start: assert property ($rose(sampling_o) |->
        $past(fall, 3) && fall_cnt == 4'h4)
        else $error("sampling began at wrong fall");
    a_hold_on_eighth: assert property (eighth |-> ##3
        ($rose(holding_o) && $rose(busy_o) && $fell(sampling_o)))
        else $error("hold did not follow eighth fall");
    a_hold_four: assert property ($rose(holding_o) |->
        holding_o [*4] ##1 (!holding_o && busy_o))
        else $error("hold length wrong");
    a_conv_length: assert property (done_o |->
        busy_cnt == 6'd36 && !busy_o)
        else $error("hold plus conversion not 36 cycles");
    a_conv_bound: assert property ($rose(busy_o) |->
        ##[1:CONV_MAX] done_o)
        else $error("conversion too slow");
    a_eight_falls: assert property ($rose(sel_n) |-> $past(eighth))
        else $error("select raised without eight falls");
    a_release_wait: assert property ($fell(sel_n) && framed |->
        high_cnt >= 6'd36)
        else $error("select high too short after frame");
    a_sclk_idle: assert property (sel_n |-> !sclk)
        else $error("shift clock active while deselected");
    a_done_pulse: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");

    c_sampling: cover property ($rose(sampling_o));
    c_done: cover property (done_o);
    c_relaunch: cover property ($fell(sel_n) && framed);
endmodule // sar_link_properties
`default_nettype wire

/* verification/serial_adc_readout_sequencer_tb.sv */
// bench: host and device back to back, plus a bench-driven second link
`timescale 1ns/1ps
`default_nettype none
module serial_adc_readout_sequencer_tb;
    function automatic logic [7:0] val(input int j);
        return 8'(j * 8'h25 + 8'hc4);
    endfunction

    logic       clk_i    = 1'b0;
    logic       reset_i  = 1'b1;
    logic       run      = 1'b0;
    logic       rd_ready = 1'b0;
    logic [7:0] ain      = val(0);
    logic [7:0] ain_b    = 8'h00;
    logic [7:0] rd_data;
    logic [7:0] result_a;
    logic [7:0] result_b;
    logic       rd_valid;
    logic       host_busy;
    logic       sampling_a;
    logic       holding_a;
    logic       busy_a;
    logic       done_a;
    logic       busy_b;
    int         fail_count = 0;
    int         check_count = 0;
    int         conv_cnt = 0;

    sar_link_if lnk();
    sar_link_if lnk_b();

    always #(sar_pkg::SYS_CLK_NS / 2) clk_i = ~clk_i;

    sar_dev_end u_sar_dev_end (.clk_i(clk_i), .reset_i(reset_i),
        .link(lnk.dev), .ain_i(ain), .sampling_o(sampling_a),
        .holding_o(holding_a), .busy_o(busy_a), .done_o(done_a),
        .result_o(result_a));
    sar_host_end u_sar_host_end (.clk_i(clk_i), .reset_i(reset_i),
        .link(lnk.host), .run_i(run), .rd_data_o(rd_data),
        .rd_valid_o(rd_valid), .rd_ready_i(rd_ready), .busy_o(host_busy));
    // second device faces the bench, which breaks the controller's rules
    sar_dev_end u_sar_dev_end_b (.clk_i(clk_i), .reset_i(reset_i),
        .link(lnk_b.dev), .ain_i(ain_b), .sampling_o(), .holding_o(),
        .busy_o(busy_b), .done_o(), .result_o(result_b));
    sar_link_properties u_sar_link_properties (.clk_i(clk_i),
        .reset_i(reset_i), .sel_n(lnk.sel_n), .sclk(lnk.sclk),
        .dout(lnk.dout), .dout_oe(lnk.dout_oe), .sampling_o(sampling_a),
        .holding_o(holding_a), .busy_o(busy_a), .done_o(done_a),
        .result_o(result_a));

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // bit captured at the end of each high phase, just before its fall
    task automatic frame_b(input int half, input logic raise,
                           output logic [7:0] got);
        got = 8'h00;
        if (lnk_b.sel_n) begin
            lnk_b.sel_n <= 1'b0;
            tick(sar_pkg::SETUP_CYC);
        end
        for (int i = 0; i < sar_pkg::RES_W; i++) begin
            lnk_b.sclk <= 1'b1;
            tick(half);
            check_bit(lnk_b.dout_oe, 1'b1);
            got = {got[6:0], lnk_b.dout_bus};
            lnk_b.sclk <= 1'b0;
            tick(half);
        end
        // select rises only once the eighth fall has been seen
        if (raise) begin
            lnk_b.sel_n <= 1'b1;
        end
    endtask

    task automatic pop(input logic [7:0] exp);
        int n;
        n = 0;
        rd_ready <= 1'b1;
        @(posedge clk_i);
        while (rd_valid !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk_i);
        end
        if (rd_valid !== 1'b1) begin
            fail_count++;
        end
        check_val(rd_data, exp);
        rd_ready <= 1'b0;
        tick(1);
    endtask

    always @(posedge clk_i) begin
        if (done_a === 1'b1) begin
            check_val(result_a, val(conv_cnt));
            ain <= val(conv_cnt + 1);
            conv_cnt <= conv_cnt + 1;
        end
    end

    initial begin
        logic [7:0] got;
        lnk_b.sel_n <= 1'b1;
        lnk_b.sclk <= 1'b0;
        tick(4);
        reset_i <= 1'b0;
        run <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            lnk_b.sclk <= ~lnk_b.sclk;
            tick(4);
        end
        check_bit(busy_b, 1'b0);
        check_bit(lnk_b.dout_oe, 1'b0);
        ain_b <= 8'h5a;
        frame_b(4, 1'b1, got);
        check_val(got, sar_pkg::RESULT_RST);
        tick(45);
        check_val(result_b, 8'h5a);
        ain_b <= 8'hc3;
        frame_b(4, 1'b1, got);
        check_val(got, 8'h5a);
        tick(10);
        check_bit(busy_b, 1'b1);
        lnk_b.sel_n <= 1'b0;
        tick(5);
        check_bit(busy_b, 1'b0);
        ain_b <= 8'h96;
        frame_b(4, 1'b0, got);
        check_val(got, 8'h5a);
        // fast second frame under low select lands inside the 36 cycles
        ain_b <= 8'h69;
        frame_b(2, 1'b0, got);
        check_val(got, 8'h5a);
        tick(4);
        check_val(result_b, 8'h5a);
        lnk_b.sel_n <= 1'b1;
        tick(41);
        check_val(result_b, 8'h69);
        repeat (6000) begin
            if (conv_cnt < sar_pkg::FIFO_DEPTH) tick(1);
        end
        tick(200);
        check_bit(host_busy, 1'b0);
        check_bit(rd_valid, 1'b1);
        run <= 1'b0;
        for (int j = 0; j < sar_pkg::FIFO_DEPTH; j++) begin
            pop(j == 0 ? sar_pkg::RESULT_RST : val(j - 1));
        end
        tick(2);
        check_bit(rd_valid, 1'b0);
        close_out();
    end

    // about three times the full-fifo run of 32 frames
    initial begin
        tick(12000);
        fail_count++;
        close_out();
    end
endmodule // serial_adc_readout_sequencer_tb
`default_nettype wire
